// ===== bench/lbpwm_bench.sv
/*
 * self-checking bench of lbpwm: apb register sequences and led duty.
 * assumes: blink on the main clock so a period is 256 cycles times the low delay plus one.
 */
`timescale 1ns/1ps
`include "lbpwm_regs.svh"
module lbpwm_bench;
  logic clk, rst, psel, penable, pwrite, slow_clk, sync_any, wdt, clr, en; // bench drivers
  logic [7:0] paddr; // bus address
  logic [31:0] pwdata, prdata, rdata; // bus data
  logic [3:0] pstrb; // lane strobes
  logic pready, pslverr, sync_o, led, err; // design answers
  logic [15:0] high_cnt; // lit cycles
  int num_errors = 0;
  int num_checks = 0;
  localparam logic [31:0] CFG0 = {16'h0000, `LBPWM_RST_WATCHDOG_RELOAD_VALUE, 8'h00}; // default cfg

  lbpwm i_lbpwm (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .SLOW_CLK_IN(slow_clk), .SYNC_ANY_IN(sync_any),
    .WDT_TIMEOUT_IN(wdt), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .SYNC_OUT(sync_o), .LED_OUT(led));
  lbpwm_led_model i_lbpwm_led_model (.clk_in(clk), .clear_in(clr), .enable_in(en), .led_in(led),
    .high_count_out(high_cnt));

  // 25 MHz main clock and free 32.768 KHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    slow_clk = 1'b0;
    forever #15259 slow_clk = ~slow_clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one apb transfer; pready, read data and error are all taken at the same rising edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; only the hang guard ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge, so the next call never assigns psel in this same time step
    @(posedge clk);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(rdata, exp);
  endtask

  // lit cycles over a window that spans whole periods
  task measure(input int cycles, input logic [15:0] exp);
    repeat (4) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    en <= 1'b1;
    repeat (cycles) @(posedge clk);
    en <= 1'b0;
    @(posedge clk);
    chk({16'h0000, high_cnt}, {16'h0000, exp});
  endtask

  // hang guard, far beyond the expected run
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    {rst, psel, penable, pwrite, sync_any, wdt, clr, en} = 8'hFF & 8'h80;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(8'h00, CFG0);
    for (int i = 1; i < 6; i++) rd_chk(8'(4 * i), 32'h0000_0000);
    bus(1'b0, 8'h18, 32'h0000_0000, 4'hF);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rdata, 32'h0000_0000);
    bus(1'b1, 8'h04, 32'h0000_0040, 4'h1);
    rd_chk(8'h04, 32'h0000_0000);
    bus(1'b1, 8'h00, CFG0 | 32'h0000_0006, 4'hF);
    rd_chk(8'h00, CFG0 | 32'h0000_0006);
    repeat (600) @(posedge clk);
    rd_chk(8'h04, 32'h0000_0040);
    measure(256, 16'h0040);
    bus(1'b1, 8'h04, 32'h0000_8000, 4'h2);
    repeat (600) @(posedge clk);
    rd_chk(8'h04, 32'h0000_8040);
    // parameters first, update enable only afterwards
    bus(1'b1, 8'h08, 32'h0000_0001, 4'hF);
    repeat (600) @(posedge clk);
    rd_chk(8'h08, 32'h0000_0000);
    measure(256, 16'h0040);
    // sync holds the counters, so no period end can clear update enable meanwhile
    bus(1'b1, 8'h00, CFG0 | 32'h0000_004E, 4'hF);
    rd_chk(8'h00, CFG0 | 32'h0000_004E);
    chk({31'h0, sync_o}, 32'h0000_0001);
    bus(1'b1, 8'h00, CFG0 | 32'h0000_000E, 4'hF);
    rd_chk(8'h00, CFG0 | 32'h0000_004E);
    bus(1'b1, 8'h00, CFG0 | 32'h0000_0006, 4'hF);
    repeat (600) @(posedge clk);
    rd_chk(8'h08, 32'h0000_0001);
    rd_chk(8'h00, CFG0 | 32'h0000_0006);
    chk({31'h0, sync_o}, 32'h0000_0000);
    measure(512, 16'h0080);
    bus(1'b1, 8'h00, CFG0 | 32'h0000_0007, 4'hF);
    measure(256, 16'h0100);
    bus(1'b1, 8'h00, CFG0 | 32'h0000_0004, 4'hF);
    measure(256, 16'h0000);
    bus(1'b1, 8'h00, CFG0 | 32'h0000_000E, 4'hF);
    measure(256, 16'h0100);
    bus(1'b1, 8'h00, CFG0 | 32'h0000_0006, 4'hF);
    sync_any <= 1'b1;
    measure(512, 16'h0200);
    sync_any <= 1'b0;
    wdt <= 1'b1;
    repeat (10) @(posedge clk);
    rd_chk(8'h00, CFG0 | 32'h0000_0007);
    wdt <= 1'b0;
    bus(1'b1, 8'h00, 32'h0000_0080, 4'h1);
    rd_chk(8'h00, CFG0);
    rd_chk(8'h04, 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_0000);
    print_verdict();
  end
endmodule // lbpwm_bench

// ===== bench/lbpwm_led_model.sv
/*
 * led at the pulse output: counts lit clock cycles inside a window.
 * assumes: window opened and cleared by the bench on the main clock.
 */
`timescale 1ns/1ps
module lbpwm_led_model (
  input wire logic clk_in,             // main clock
  input wire logic clear_in,           // restart the count
  input wire logic enable_in,          // window open
  input wire logic led_in,             // pulse output
  output logic [15:0] high_count_out   // lit cycles seen
);
  // brightness seen as lit share of a window, not edge timing
  always_ff @(posedge clk_in) begin
    if (clear_in) begin
      high_count_out <= 16'h0000;
    end else if (enable_in && led_in) begin
      high_count_out <= high_count_out + 16'h0001;
    end
  end
endmodule // lbpwm_led_model

// ===== bench/lbpwm_sva.sv
/*
 * concurrent checks on the apb answer and the sync output of lbpwm.
 * assumes: bound to lbpwm, one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
module lbpwm_sva (
  input wire logic CLK_IN,           // main clock
  input wire logic RESET_IN,         // synchronous reset
  input wire logic PSEL_IN,          // apb select
  input wire logic PENABLE_IN,       // apb access phase
  input wire logic PWRITE_IN,        // apb direction
  input wire logic [7:0] PADDR_IN,   // apb address
  input wire logic [31:0] PWDATA_IN, // apb write data
  input wire logic [3:0] PSTRB_IN,   // apb strobes
  input wire logic [31:0] PRDATA_OUT, // apb read data
  input wire logic PREADY_OUT,       // apb ready
  input wire logic PSLVERR_OUT,      // apb error
  input wire logic SYNC_OUT          // own sync bit
);
  // one domain, so clock and disable are given once
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  a_ready_after_setup: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("ready missing after setup");
  a_ready_needs_setup: assert property (PREADY_OUT |-> $past(PSEL_IN && !PENABLE_IN))
    else $error("ready without setup");
  a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held too long");
  a_err_unmapped: assert property (PSEL_IN && !PENABLE_IN && PADDR_IN > 8'h14 |=> PSLVERR_OUT)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (
    PSEL_IN && !PENABLE_IN && PADDR_IN <= 8'h14 && PADDR_IN[1:0] == 2'h0 |=> !PSLVERR_OUT)
    else $error("error on mapped address");
  a_err_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0000_0000)
    else $error("error without ready or with data");
  a_rdata_idle: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0000_0000)
    else $error("read data outside access");
  // sync bit lands in cfg at the access edge, the pin follows one edge later
  a_sync_follow: assert property (
    PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == 8'h00 && PSTRB_IN[0] && !PWDATA_IN[7]
    |-> ##2 SYNC_OUT == $past(PWDATA_IN[3], 2))
    else $error("sync output does not follow write");
endmodule // lbpwm_sva

bind lbpwm lbpwm_sva i_lbpwm_sva (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PSTRB_IN(PSTRB_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .SYNC_OUT(SYNC_OUT));

// ===== rtl/lbpwm.sv
/*
 * breathing/blinking pulse-width led generator with its apb register file.
 * assumes: single clock CLK_IN, synchronous active-high RESET_IN, slow
 * 32.768 KHz clock and the watchdog timeout and group-sync levels arrive
 * asynchronously on pins.
 */
// Function
// [R1] period runs zero to FFh, FEh or FCh
// [R2] counter wrap to zero ends period, commits
// [R3] registers accept 32, 16, 8-bit writes
// [R4] configuration writes take effect immediately
// [R5] duty limits commit every period end
// [R6] delay, step, interval commit only when enabled
// [R7] limits read operating copy, bytes independent
// [R8] symmetry bit selects asymmetric four-segment ramps
// [R9] watchdog reload field, resets to 14h
// [R10] soft reset bit restores defaults, self-clears
// [R11] update enable set-only, hardware clears after commit
// [R12] size field selects 8, 7, 6-bit counter
// [R13] any synchronize bit holds all counters
// [R14] software sets sync, programs, then clears all
// [R15] clock select picks main or slow clock; code honours it in blink only, other modes use the slow clock
// [R16] mode field: on, blink, breathe, off-and-clear
// [R17] at upper limit hold high time, then fall
// [R18] at lower limit hold low time, then rise
// [R19] blink duty comes from lower limit byte
// [R20] software writes parameters before update enable
// [R21] led active while counter below duty
// [R22] blink uses 8-bit counter behind prescaler
// [R23] segment index from duty bits and ramp direction
// [R24] interval n waits n plus one periods
// [R25] watchdog timeout forces always-on mode
`timescale 1ns/1ps
`include "lbpwm_regs.svh"

module lbpwm (
  input wire logic CLK_IN,           // main clock, 25 MHz
  input wire logic RESET_IN,         // synchronous reset, active high
  input wire logic PSEL_IN,          // apb select
  input wire logic PENABLE_IN,       // apb access phase
  input wire logic PWRITE_IN,        // apb direction, high writes
  input wire logic [7:0] PADDR_IN,   // apb byte address
  input wire logic [31:0] PWDATA_IN, // apb write data
  input wire logic [3:0] PSTRB_IN,   // apb byte lane strobes
  input wire logic SLOW_CLK_IN,      // 32.768 KHz clock pin
  input wire logic SYNC_ANY_IN,      // any other instance synchronizing
  input wire logic WDT_TIMEOUT_IN,   // watchdog timeout level
  output logic [31:0] PRDATA_OUT,    // apb read data
  output logic PREADY_OUT,           // apb ready
  output logic PSLVERR_OUT,          // apb error, unmapped address
  output logic SYNC_OUT,             // own synchronize bit to the group
  output logic LED_OUT               // pulse output, active high
);

  lbpwm_pkg::lbpwm_state_t st;      // registered state
  lbpwm_pkg::lbpwm_state_t next_st; // next state

  // byte-lane merge of a write into a register word
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wdat,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // period maximum for a size field, blink always full width
  function automatic logic [7:0] period_max(input logic [1:0] size, input logic blink);
    logic [7:0] m;
    m = `LBPWM_MAX_8BIT;
    if (!blink && size == 2'h1) begin
      m = `LBPWM_MAX_7BIT;
    end else if (!blink && size == 2'h2) begin
      m = `LBPWM_MAX_6BIT;
    end
    return m;
  endfunction

  // pick a 4-bit segment field out of a step or interval word
  function automatic logic [3:0] seg_field(input logic [31:0] word, input logic [2:0] idx);
    return word[idx*4 +: 4];
  endfunction

  // decoded state used by the process below
  logic is_write;      // write access completing this edge
  logic is_setup;      // apb setup cycle
  logic slow_tick;     // rising edge of the slow clock
  logic base_tick;     // selected counting clock tick
  logic pwm_tick;      // period counter advances
  logic period_end;    // counter wraps this cycle
  logic hold_all;      // group synchronize active
  logic [7:0] pmax;    // current period maximum
  logic [7:0] duty_now; // duty used for comparison
  logic [2:0] seg_idx; // ramp segment index
  logic [3:0] seg_step; // step field of the current segment
  logic [8:0] step_amt; // duty change per update
  logic [8:0] sum;     // rising duty before clipping
  logic [31:0] wmerge; // merged write word
  logic [31:0] rd_word; // read mux
  logic addr_ok;       // mapped register
  logic [7:0] lim_max; // operating upper limit
  logic [7:0] lim_min; // operating lower limit

  // one combinational pass over the whole state
  always_comb begin
    next_st = st;
    is_setup = PSEL_IN && !PENABLE_IN;
    is_write = PSEL_IN && PENABLE_IN && PWRITE_IN && st.rsp.ready;
    lim_max = st.limits_op[`LBPWM_LIM_MAX_MSB:`LBPWM_LIM_MAX_LSB];
    lim_min = st.limits_op[`LBPWM_LIM_MIN_MSB:`LBPWM_LIM_MIN_LSB];

    // pin synchronisers; only the second stage and later are read
    next_st.slow_sync = {st.slow_sync[1:0], SLOW_CLK_IN};
    next_st.wdt_sync = {st.wdt_sync[1:0], WDT_TIMEOUT_IN};
    next_st.sync_any = {st.sync_any[0], SYNC_ANY_IN};
    slow_tick = st.slow_sync[1] && !st.slow_sync[2];

    // counting base: main clock only in blink with select set
    if (st.cfg.operating_mode_alias == lbpwm_pkg::LBPWM_MODE_BLINK && st.cfg.clock_select) begin
      base_tick = 1'b1; // [R15]
    end else begin
      base_tick = slow_tick; // [R15]
    end
    hold_all = st.cfg.synchronize || st.sync_any[1]; // [R13]

    // blink inserts the prescaler, reloaded from the low delay
    pwm_tick = 1'b0;
    if (st.cfg.operating_mode_alias == lbpwm_pkg::LBPWM_MODE_BLINK) begin
      if (base_tick && !hold_all) begin
        if (st.prescale == 12'h000) begin
          next_st.prescale = st.delay_op[`LBPWM_DLY_LOW_MSB:`LBPWM_DLY_LOW_LSB]; // [R22]
          pwm_tick = 1'b1; // [R22]
        end else begin
          next_st.prescale = st.prescale - 12'h001;
        end
      end
    end else begin
      pwm_tick = base_tick && !hold_all;
    end

    // period counter and its wrap
    pmax = period_max(st.cfg.counter_size_param,
                      st.cfg.operating_mode_alias == lbpwm_pkg::LBPWM_MODE_BLINK); // [R1] [R12] [R22]
    period_end = 1'b0;
    if (pwm_tick) begin
      if (st.period_counter >= pmax) begin
        next_st.period_counter = 8'h00; // [R1]
        period_end = 1'b1; // [R2]
      end else begin
        next_st.period_counter = st.period_counter + 8'h01;
      end
    end

    // segment index and step size for the ramp engine
    if (st.cfg.symmetry) begin
      seg_idx = {st.phase == lbpwm_pkg::LBPWM_FALL, st.duty[7:6]}; // [R8] [R23]
    end else begin
      seg_idx = st.duty[7:5]; // [R8] [R23]
    end
    // coarser sizes drop the low step bits
    seg_step = seg_field(st.step_op, seg_idx);
    unique case (st.cfg.counter_size_param)
      2'h1: step_amt = {6'h00, seg_step[3:1]} + 9'h001;
      2'h2: step_amt = {7'h00, seg_step[3:2]} + 9'h001;
      default: step_amt = {5'h00, seg_step} + 9'h001;
    endcase
    sum = {1'b0, st.duty} + step_amt;

    // breathing engine steps once per period end
    if (st.cfg.operating_mode_alias == lbpwm_pkg::LBPWM_MODE_BREATH && period_end) begin
      unique case (st.phase)
        lbpwm_pkg::LBPWM_RISE: begin
          if (st.duty >= lim_max) begin
            next_st.phase = lbpwm_pkg::LBPWM_HOLD_HIGH; // [R17]
            next_st.wait_cnt = st.delay_op[`LBPWM_DLY_HIGH_MSB:`LBPWM_DLY_HIGH_LSB]; // [R17]
          end else if (st.wait_cnt != 12'h000) begin
            next_st.wait_cnt = st.wait_cnt - 12'h001; // [R24]
          end else begin
            // saturate rather than wrap past full scale
            next_st.duty = sum[8] ? 8'hFF : sum[7:0];
            next_st.wait_cnt = {8'h00, seg_field(st.int_op, seg_idx)}; // [R24]
          end
        end
        lbpwm_pkg::LBPWM_HOLD_HIGH: begin
          if (st.wait_cnt != 12'h000) begin
            next_st.wait_cnt = st.wait_cnt - 12'h001;
          end else begin
            next_st.phase = lbpwm_pkg::LBPWM_FALL; // [R17]
          end
        end
        lbpwm_pkg::LBPWM_FALL: begin
          if (st.duty <= lim_min) begin
            next_st.phase = lbpwm_pkg::LBPWM_HOLD_LOW; // [R18]
            next_st.wait_cnt = st.delay_op[`LBPWM_DLY_LOW_MSB:`LBPWM_DLY_LOW_LSB]; // [R18]
          end else if (st.wait_cnt != 12'h000) begin
            next_st.wait_cnt = st.wait_cnt - 12'h001; // [R24]
          end else begin
            next_st.duty = ({1'b0, st.duty} > step_amt) ? st.duty - step_amt[7:0] : 8'h00;
            next_st.wait_cnt = {8'h00, seg_field(st.int_op, seg_idx)}; // [R24]
          end
        end
        lbpwm_pkg::LBPWM_HOLD_LOW: begin
          if (st.wait_cnt != 12'h000) begin
            next_st.wait_cnt = st.wait_cnt - 12'h001;
          end else begin
            next_st.phase = lbpwm_pkg::LBPWM_RISE; // [R18]
          end
        end
      endcase
    end

    // group synchronize holds every counter at its start value
    if (hold_all) begin
      next_st.period_counter = 8'h00; // [R13]
      next_st.prescale = 12'h000; // [R13]
      next_st.wait_cnt = 12'h000; // [R13]
      next_st.skew_cnt = st.skew; // [R13]
    end else if (base_tick && st.skew_cnt != 8'h00) begin
      next_st.skew_cnt = st.skew_cnt - 8'h01;
    end

    // period-end commits of the holding copies
    if (period_end) begin
      next_st.limits_op = st.limits_hold; // [R2] [R5]
      if (st.cfg.update_enable) begin
        next_st.delay_op = st.delay_hold; // [R6]
        next_st.step_op = st.step_hold; // [R6]
        next_st.int_op = st.int_hold; // [R6]
        next_st.cfg.update_enable = 1'b0; // [R11]
      end
    end

    // register writes; a set of update enable beats the clear above
    wmerge = 32'h0000_0000;
    if (is_write) begin
      unique case (PADDR_IN)
        `LBPWM_OFF_BREATH_CONFIG: begin
          wmerge = lane_merge({15'h0000, st.cfg.symmetry, st.cfg.watchdog_reload_value, 1'b0,
                               st.cfg.update_enable, st.cfg.counter_size_param, st.cfg.synchronize,
                               st.cfg.clock_select, st.cfg.operating_mode_alias},
                              PWDATA_IN, PSTRB_IN); // [R3]
          next_st.cfg.symmetry = wmerge[`LBPWM_CFG_SYMMETRY_BIT]; // [R4] [R8]
          next_st.cfg.watchdog_reload_value = wmerge[`LBPWM_CFG_WDT_MSB:`LBPWM_CFG_WDT_LSB]; // [R9]
          next_st.cfg.counter_size_param = wmerge[`LBPWM_CFG_SIZE_MSB:`LBPWM_CFG_SIZE_LSB]; // [R12]
          next_st.cfg.synchronize = wmerge[`LBPWM_CFG_SYNC_BIT]; // [R13]
          next_st.cfg.clock_select = wmerge[`LBPWM_CFG_CLKSEL_BIT]; // [R15]
          next_st.cfg.operating_mode_alias =
            lbpwm_pkg::lbpwm_mode_t'(wmerge[`LBPWM_CFG_MODE_MSB:`LBPWM_CFG_MODE_LSB]); // [R16]
          if (PSTRB_IN[0] && PWDATA_IN[`LBPWM_CFG_UPDATE_EN_BIT]) begin
            next_st.cfg.update_enable = 1'b1; // [R11]
          end
        end
        `LBPWM_OFF_DUTY_LIMITS: begin
          wmerge = lane_merge({16'h0000, st.limits_hold}, PWDATA_IN, PSTRB_IN); // [R3] [R7]
          next_st.limits_hold = wmerge[15:0]; // [R5]
        end
        `LBPWM_OFF_HOLD_DELAYS: begin
          wmerge = lane_merge({8'h00, st.delay_hold}, PWDATA_IN, PSTRB_IN); // [R3]
          next_st.delay_hold = wmerge[23:0]; // [R6]
        end
        `LBPWM_OFF_RAMP_STEP_SIZES: begin
          next_st.step_hold = lane_merge(st.step_hold, PWDATA_IN, PSTRB_IN); // [R3] [R6]
        end
        `LBPWM_OFF_RAMP_INTERVALS: begin
          next_st.int_hold = lane_merge(st.int_hold, PWDATA_IN, PSTRB_IN); // [R3] [R6]
        end
        `LBPWM_OFF_OUTPUT_SKEW_DELAY: begin
          wmerge = lane_merge({24'h000000, st.skew}, PWDATA_IN, PSTRB_IN); // [R3]
          next_st.skew = wmerge[7:0];
        end
        default: begin
          next_st.skew = st.skew; // unmapped write is dropped
        end
      endcase
    end

    // watchdog timeout overrides the mode to always on
    if (st.wdt_sync[1] && !st.wdt_sync[2]) begin
      next_st.cfg.operating_mode_alias = lbpwm_pkg::LBPWM_MODE_ON; // [R25]
    end

    // mode off clears the engine and parks its counters
    if (st.cfg.operating_mode_alias == lbpwm_pkg::LBPWM_MODE_OFF) begin
      next_st.period_counter = 8'h00; // [R16]
      next_st.prescale = 12'h000; // [R16]
      next_st.duty = 8'h00; // [R16]
      next_st.wait_cnt = 12'h000; // [R16]
      next_st.phase = lbpwm_pkg::LBPWM_RISE; // [R16]
      next_st.skew_cnt = st.skew;
    end

    // output compare; in breathe and blink, skew keeps the output off after enable or sync
    duty_now = (st.cfg.operating_mode_alias == lbpwm_pkg::LBPWM_MODE_BLINK) ? lim_min : st.duty; // [R19]
    unique case (st.cfg.operating_mode_alias)
      lbpwm_pkg::LBPWM_MODE_ON: next_st.led = 1'b1; // [R16]
      lbpwm_pkg::LBPWM_MODE_OFF: next_st.led = 1'b0; // [R16]
      default: next_st.led = (st.skew_cnt == 8'h00) && (st.period_counter < duty_now); // [R21]
    endcase
    next_st.sync_out = st.cfg.synchronize;

    // read mux shows operating copies, never the holding ones
    addr_ok = 1'b1;
    unique case (PADDR_IN)
      `LBPWM_OFF_BREATH_CONFIG: rd_word = {15'h0000, st.cfg.symmetry, st.cfg.watchdog_reload_value, 1'b0,
                                           st.cfg.update_enable, st.cfg.counter_size_param,
                                           st.cfg.synchronize, st.cfg.clock_select,
                                           st.cfg.operating_mode_alias}; // [R10] [R11]
      `LBPWM_OFF_DUTY_LIMITS: rd_word = {16'h0000, st.limits_op}; // [R7]
      `LBPWM_OFF_HOLD_DELAYS: rd_word = {8'h00, st.delay_op};
      `LBPWM_OFF_RAMP_STEP_SIZES: rd_word = st.step_op;
      `LBPWM_OFF_RAMP_INTERVALS: rd_word = st.int_op;
      `LBPWM_OFF_OUTPUT_SKEW_DELAY: rd_word = {24'h000000, st.skew};
      default: begin
        rd_word = 32'h0000_0000;
        addr_ok = 1'b0;
      end
    endcase

    // no wait state: answer registered in setup, shown in the first access cycle
    next_st.rsp.ready = is_setup;
    next_st.rsp.slverr = is_setup && !addr_ok;
    next_st.rsp.rdata = (is_setup && !PWRITE_IN) ? rd_word : 32'h0000_0000;

    // soft reset restores every register, bit itself reads zero
    if (is_write && PADDR_IN == `LBPWM_OFF_BREATH_CONFIG && PSTRB_IN[0] &&
        PWDATA_IN[`LBPWM_CFG_SOFT_RESET_BIT]) begin
      next_st.cfg = '0; // [R10]
      next_st.cfg.watchdog_reload_value = `LBPWM_RST_WATCHDOG_RELOAD_VALUE; // [R9] [R10]
      next_st.limits_hold = 16'h0000; // [R10]
      next_st.limits_op = 16'h0000;
      next_st.delay_hold = 24'h000000;
      next_st.delay_op = 24'h000000;
      next_st.step_hold = `LBPWM_RST_ZERO32;
      next_st.step_op = `LBPWM_RST_ZERO32;
      next_st.int_hold = `LBPWM_RST_ZERO32;
      next_st.int_op = `LBPWM_RST_ZERO32;
      next_st.skew = 8'h00;
      next_st.skew_cnt = 8'h00;
      next_st.duty = 8'h00;
      next_st.phase = lbpwm_pkg::LBPWM_RISE;
    end
  end

  // state register; reset takes constants only
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      st <= '0;
      st.cfg.watchdog_reload_value <= `LBPWM_RST_WATCHDOG_RELOAD_VALUE; // [R9]
    end else begin
      st <= next_st;
    end
  end

  // every output is a flip-flop of the state
  assign PRDATA_OUT = st.rsp.rdata;
  assign PREADY_OUT = st.rsp.ready;
  assign PSLVERR_OUT = st.rsp.slverr;
  assign SYNC_OUT = st.sync_out;
  assign LED_OUT = st.led;

endmodule // lbpwm

// ===== rtl/lbpwm_pkg.sv
/*
 * types of the breathing/blinking pulse-width block.
 * assumes: used by scoped name only, never imported.
 */
package lbpwm_pkg;

  // operating modes of the mode field
  typedef enum logic [1:0] {
    LBPWM_MODE_OFF = 2'h0,
    LBPWM_MODE_BREATH = 2'h1,
    LBPWM_MODE_BLINK = 2'h2,
    LBPWM_MODE_ON = 2'h3
  } lbpwm_mode_t;

  // breathing ramp phases
  typedef enum logic [1:0] {
    LBPWM_RISE,
    LBPWM_HOLD_HIGH,
    LBPWM_FALL,
    LBPWM_HOLD_LOW
  } lbpwm_phase_t;

  // software configuration fields
  typedef struct packed {
    logic symmetry;
    logic [7:0] watchdog_reload_value;
    logic update_enable;
    logic [1:0] counter_size_param;
    logic synchronize;
    logic clock_select;
    lbpwm_mode_t operating_mode_alias;
  } lbpwm_cfg_t;

  // apb answer carried as one group
  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } lbpwm_apb_rsp_t;

  // whole state of the block
  typedef struct packed {
    lbpwm_cfg_t cfg;
    logic [15:0] limits_hold;
    logic [15:0] limits_op;
    logic [23:0] delay_hold;
    logic [23:0] delay_op;
    logic [31:0] step_hold;
    logic [31:0] step_op;
    logic [31:0] int_hold;
    logic [31:0] int_op;
    logic [7:0] skew;
    logic [7:0] period_counter;
    logic [11:0] prescale;
    logic [7:0] duty;
    logic [11:0] wait_cnt;
    lbpwm_phase_t phase;
    logic [7:0] skew_cnt;
    logic led;
    logic sync_out;
    logic [2:0] slow_sync;
    logic [2:0] wdt_sync;
    logic [1:0] sync_any;
    lbpwm_apb_rsp_t rsp;
  } lbpwm_state_t;

endpackage : lbpwm_pkg

// ===== rtl/lbpwm_regs.svh
/*
 * register offsets, field positions, reset values and counts of the
 * breathing/blinking pulse-width block.
 * assumes: included by bare name, definitions only.
 */
`ifndef LBPWM_REGS_SVH
`define LBPWM_REGS_SVH

// byte offsets on the register bus
`define LBPWM_OFF_BREATH_CONFIG 8'h00
`define LBPWM_OFF_DUTY_LIMITS 8'h04
`define LBPWM_OFF_HOLD_DELAYS 8'h08
`define LBPWM_OFF_RAMP_STEP_SIZES 8'h0C
`define LBPWM_OFF_RAMP_INTERVALS 8'h10
`define LBPWM_OFF_OUTPUT_SKEW_DELAY 8'h14

// breath_config field positions
`define LBPWM_CFG_SYMMETRY_BIT 16
`define LBPWM_CFG_WDT_MSB 15
`define LBPWM_CFG_WDT_LSB 8
`define LBPWM_CFG_SOFT_RESET_BIT 7
`define LBPWM_CFG_UPDATE_EN_BIT 6
`define LBPWM_CFG_SIZE_MSB 5
`define LBPWM_CFG_SIZE_LSB 4
`define LBPWM_CFG_SYNC_BIT 3
`define LBPWM_CFG_CLKSEL_BIT 2
`define LBPWM_CFG_MODE_MSB 1
`define LBPWM_CFG_MODE_LSB 0

// duty_limits and hold_delays field positions
`define LBPWM_LIM_MAX_MSB 15
`define LBPWM_LIM_MAX_LSB 8
`define LBPWM_LIM_MIN_MSB 7
`define LBPWM_LIM_MIN_LSB 0
`define LBPWM_DLY_HIGH_MSB 23
`define LBPWM_DLY_HIGH_LSB 12
`define LBPWM_DLY_LOW_MSB 11
`define LBPWM_DLY_LOW_LSB 0

// reset values
`define LBPWM_RST_WATCHDOG_RELOAD_VALUE 8'h14
`define LBPWM_RST_ZERO32 32'h0000_0000

// period maxima per counter size
`define LBPWM_MAX_8BIT 8'hFF
`define LBPWM_MAX_7BIT 8'hFE
`define LBPWM_MAX_6BIT 8'hFC

`endif
